// file: display_serial_host_port.sv
`timescale 1ns/100ps
// serial host port: frames, identity check, command decode, word assembly
module display_serial_host_port
  import display_serial_pkg::*;
#(
  parameter logic [4:0] ID_UPPER = 5'h15  // arbitrary value, fixed per device
)(
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic        serial_clk,
  input  wire logic        cs_n,
  input  wire logic        serial_in,
  output logic             serial_out,
  input  wire logic        bus_select_pin_3,
  input  wire logic        bus_select_pin_2,
  input  wire logic        bus_select_pin_1,
  input  wire logic        bus_select_low_or_addr_bit,
  output logic             index_wr,
  output logic [15:0]      index_value,
  output logic             instr_wr,
  output logic [15:0]      instr_word,
  output logic             pixel_wr,
  output logic [17:0]      pixel_data,
  output logic             rd_req,
  output logic             rd_register_select,
  input  wire logic [15:0] rd_data,
  output logic             spi_selected,
  output logic             frame_active,
  output logic             id_mismatch
);
  logic [1:0]   rst_sync_r;
  logic         rst_int;
  logic         cs_s;
  logic         cs_prev_r;
  logic         tgl_s;
  logic         tgl_prev_r;
  logic [2:0]   bus_s;
  logic         id_bit_s;
  logic [7:0]   rx_byte;
  logic         rx_toggle;
  logic         frame_start;
  logic         frame_end;
  logic         byte_evt;
  frame_state_t state_r;
  logic         rs_r;
  logic         half_r;
  logic [7:0]   hi_r;
  logic [2:0]   byte_cnt_r;
  logic         rd_pend_r;
  logic         tx_enable_r;
  logic [15:0]  tx_word_r;
  logic [15:0]  word;
  logic [5:0]   identity;
  logic         start_ok;

  // reset released through two flops; assertion stays asynchronous
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync_r <= 2'b00;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rst_int = ~rst_sync_r[1];

  // pins and link events brought into the system clock domain
  level_sync u_cs_sync (
    .clk  (sys_clk),
    .arst (rst_int),
    .d    (~cs_n),
    .q    (cs_s)
  );
  level_sync u_tgl_sync (
    .clk  (sys_clk),
    .arst (rst_int),
    .d    (rx_toggle),
    .q    (tgl_s)
  );

  // the four straps each pass two flops before decode
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_strap
      logic pin;
      logic pin_s;
      if (gi == 0) begin : g_id
        assign pin = bus_select_low_or_addr_bit;
      end else if (gi == 1) begin : g_p1
        assign pin = bus_select_pin_1;
      end else if (gi == 2) begin : g_p2
        assign pin = bus_select_pin_2;
      end else begin : g_p3
        assign pin = bus_select_pin_3;
      end
      level_sync u_strap (
        .clk  (sys_clk),
        .arst (rst_int),
        .d    (pin),
        .q    (pin_s)
      );
    end
  endgenerate
  assign bus_s    = {g_strap[3].pin_s, g_strap[2].pin_s, g_strap[1].pin_s};
  assign id_bit_s = g_strap[0].pin_s;

  // link side on the serial clock; chip select high is its frame reset
  serial_link_shifter u_link (
    .serial_clk (serial_clk),
    .cs_n       (cs_n),
    .sys_rst    (rst_int),
    .serial_in  (serial_in),
    .tx_enable  (tx_enable_r),
    .tx_word    (tx_word_r),
    .rx_byte    (rx_byte),
    .rx_toggle  (rx_toggle),
    .serial_out (serial_out)
  );

  // edge history for chip select and byte toggle
  always_ff @(posedge sys_clk or posedge rst_int) begin
    if (rst_int) begin
      cs_prev_r  <= 1'b0;
      tgl_prev_r <= 1'b0;
    end else begin
      cs_prev_r  <= cs_s;
      tgl_prev_r <= tgl_s;
    end
  end

  assign frame_start = cs_s & ~cs_prev_r;
  assign frame_end   = ~cs_s & cs_prev_r;
  assign byte_evt    = tgl_s ^ tgl_prev_r;
  assign identity    = {ID_UPPER, id_bit_s};
  assign start_ok    = (rx_byte[7:ID_POS] == identity);
  assign word        = {hi_r, rx_byte};

  // mode select from the straps; host must strap before frames start
  always_ff @(posedge sys_clk or posedge rst_int) begin
    if (rst_int) begin
      spi_selected <= 1'b0;
    end else begin
      spi_selected <= (bus_s == BUS_SEL_SERIAL);
    end
  end

  // frame sequencing; a byte landing with the end is still handled first
  always_ff @(posedge sys_clk or posedge rst_int) begin
    if (rst_int) begin
      state_r <= ST_IDLE;
      rs_r    <= 1'b0;
    end else begin
      if (frame_start) begin
        state_r <= spi_selected ? ST_START : ST_SKIP;
      end else if (byte_evt) begin
        case (state_r)
          ST_START: begin
            if (start_ok) begin
              rs_r    <= rx_byte[RS_POS];
              state_r <= rx_byte[RW_POS] ? ST_READ : ST_WRITE;
            end else begin
              state_r <= ST_SKIP;
            end
          end
          default: state_r <= state_r;
        endcase
      end
      if (frame_end) begin
        state_r <= ST_IDLE;
      end
    end
  end

  // byte pairing for writes; a new frame restarts at the upper byte
  always_ff @(posedge sys_clk or posedge rst_int) begin
    if (rst_int) begin
      half_r <= 1'b0;
      hi_r   <= BYTE_RESET;
    end else if (frame_start || frame_end) begin
      half_r <= 1'b0;
    end else if (byte_evt && state_r == ST_WRITE) begin
      half_r <= ~half_r;
      if (!half_r) begin
        hi_r <= rx_byte;
      end
    end
  end

  // write strobes; each is a one-cycle pulse with its data held after
  always_ff @(posedge sys_clk or posedge rst_int) begin
    if (rst_int) begin
      index_wr    <= 1'b0;
      instr_wr    <= 1'b0;
      pixel_wr    <= 1'b0;
      index_value <= INDEX_RESET;
      instr_word  <= WORD_RESET;
      pixel_data  <= PIXEL_RESET;
    end else begin
      index_wr <= 1'b0;
      instr_wr <= 1'b0;
      pixel_wr <= 1'b0;
      if (byte_evt && state_r == ST_WRITE && half_r && !frame_start) begin
        if (!rs_r) begin
          index_wr    <= 1'b1;
          index_value <= word;
        end else if (index_value == PIXEL_DATA_REG_INDEX) begin
          pixel_wr   <= 1'b1;
          // red and blue regain a low bit copied from their top bit
          pixel_data <= {word[15:11], word[15], word[10:5],
                         word[4:0], word[4]};
        end else begin
          instr_wr   <= 1'b1;
          instr_word <= word;
        end
      end
    end
  end

  // bytes counted from the start byte as 0; count wraps 6,7 for word pairs
  always_ff @(posedge sys_clk or posedge rst_int) begin
    if (rst_int) begin
      byte_cnt_r <= 3'h0;
    end else if (frame_start) begin
      byte_cnt_r <= 3'h0;
    end else if (byte_evt) begin
      byte_cnt_r <= (byte_cnt_r == LAST_BYTE_COUNT) ? FIRST_DATA_BYTE
                                                    : byte_cnt_r + 3'h1;
    end
  end

  // read fetches: one on entry, then one after each upper byte goes out,
  // which leaves eight serial clocks for the next word to settle
  always_ff @(posedge sys_clk or posedge rst_int) begin
    if (rst_int) begin
      rd_req             <= 1'b0;
      rd_register_select <= 1'b0;
      rd_pend_r          <= 1'b0;
    end else begin
      rd_req    <= 1'b0;
      rd_pend_r <= rd_req;
      if (byte_evt && !frame_end) begin
        if (state_r == ST_START && start_ok && rx_byte[RW_POS]) begin
          rd_req             <= 1'b1;
          rd_register_select <= rx_byte[RS_POS];
        end else if (state_r == ST_READ && byte_cnt_r == FIRST_DATA_BYTE) begin
          rd_req <= 1'b1;
        end
      end
    end
  end

  // read word is held still while the link copies it at an upper byte
  always_ff @(posedge sys_clk or posedge rst_int) begin
    if (rst_int) begin
      tx_word_r   <= WORD_RESET;
      tx_enable_r <= 1'b0;
    end else begin
      if (rd_pend_r) begin
        tx_word_r <= rd_data;
      end
      if (frame_start || frame_end) begin
        tx_enable_r <= 1'b0;
      end else if (byte_evt && state_r == ST_START) begin
        tx_enable_r <= start_ok & rx_byte[RW_POS];
      end
    end
  end

  // status flags for the surrounding logic
  always_ff @(posedge sys_clk or posedge rst_int) begin
    if (rst_int) begin
      frame_active <= 1'b0;
      id_mismatch  <= 1'b0;
    end else begin
      frame_active <= cs_s;
      id_mismatch  <= byte_evt && state_r == ST_START && !start_ok;
    end
  end
endmodule

// file: display_serial_host_port_sva.sv
`timescale 1ns/100ps
// port-level checks of the serial host port, sys_clk side only
module display_serial_host_port_sva
  import display_serial_pkg::*;
(
  input wire logic        sys_clk,
  input wire logic        rst_n,
  input wire logic        index_wr,
  input wire logic [15:0] index_value,
  input wire logic        instr_wr,
  input wire logic        pixel_wr,
  input wire logic [17:0] pixel_data,
  input wire logic        rd_req,
  input wire logic        spi_selected,
  input wire logic        id_mismatch
);
  logic any_wr;

  // words are 16 serial clocks apart, so strobes can never crowd each other
  assign any_wr = index_wr | instr_wr | pixel_wr;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  AST_ONE_KIND: assert property ($onehot0({index_wr, instr_wr, pixel_wr}))
    else $error("two write strobes at once");
  AST_MODE_GATE: assert property (any_wr || rd_req |-> spi_selected)
    else $error("transfer outside serial mode");
  AST_PIXEL_DEST: assert property (pixel_wr |-> index_value == PIXEL_DATA_REG_INDEX)
    else $error("pixel write with other index");
  AST_WIDEN: assert property (pixel_wr |-> pixel_data[12] == pixel_data[17] && pixel_data[0] == pixel_data[5])
    else $error("pixel not widened");
  AST_INDEX_HOLD: assert property (!index_wr |-> $stable(index_value))
    else $error("index moved without a write");
  AST_WORD_GAP: assert property (any_wr |=> !any_wr [*8])
    else $error("write strobes too close");
  AST_RD_GAP: assert property (rd_req |=> !rd_req [*8])
    else $error("read requests too close");
  AST_REJECT: assert property (id_mismatch |=> !(any_wr || rd_req) [*8])
    else $error("activity after identity reject");

  cover property (pixel_wr);
  cover property (rd_req);
  cover property (id_mismatch);
endmodule

bind display_serial_host_port display_serial_host_port_sva i_display_serial_host_port_sva (
  .sys_clk, .rst_n, .index_wr, .index_value, .instr_wr, .pixel_wr, .pixel_data,
  .rd_req, .spi_selected, .id_mismatch);

// file: display_serial_pkg.sv
package display_serial_pkg;
  localparam logic [2:0]  BUS_SEL_SERIAL       = 3'h2;    // pins 3,2,1 = low, high, low
  localparam logic [15:0] PIXEL_DATA_REG_INDEX = 16'h0022;
  localparam int          ID_POS               = 2;       // identity sits in byte[7:2]
  localparam int          RS_POS               = 1;       // register select flag
  localparam int          RW_POS               = 0;       // direction flag
  localparam logic [2:0]  DUMMY_BYTES          = 3'h5;
  localparam logic [2:0]  FIRST_DATA_BYTE      = 3'h6;    // counted with start byte as 0
  localparam logic [2:0]  LAST_BYTE_COUNT      = 3'h7;
  localparam logic [15:0] INDEX_RESET          = 16'h0000;
  localparam logic [15:0] WORD_RESET           = 16'h0000;
  localparam logic [17:0] PIXEL_RESET          = 18'h00000;
  localparam logic [7:0]  BYTE_RESET           = 8'h00;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_START,
    ST_WRITE,
    ST_READ,
    ST_SKIP
  } frame_state_t;
endpackage

// file: level_sync.sv
`timescale 1ns/100ps
// two-stage synchroniser for a level; first stage feeds only the second
module level_sync (
  input  wire logic clk,
  input  wire logic arst,
  input  wire logic d,
  output logic      q
);
  logic meta_r;

  always_ff @(posedge clk or posedge arst) begin
    if (arst) begin
      meta_r <= 1'b0;
      q      <= 1'b0;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule

// file: serial_host_model.sv
`timescale 1ns/100ps
// host side of the link; its clock stands high between frames
module serial_host_model (
  output logic      serial_clk,
  output logic      cs_n,
  output logic      serial_in,
  input  wire logic serial_out
);
  logic [7:0] tx_q[$];
  logic [7:0] rx_q[$];

  initial begin
    serial_clk = 1'b1;
    cs_n = 1'b1;
    serial_in = 1'b1;
  end

  // start byte, nb whole bytes, then pb stray bits that must be dropped
  task automatic xfer(input logic [7:0] sb, input int nb, input int pb);
    logic [7:0] b;
    logic [7:0] r;
    b = sb;
    rx_q = {};
    #17 cs_n = 1'b0;
    #50;
    for (int i = 0; i <= nb + (pb > 0); i++) begin
      if (i > 0) b = (i > nb) ? 8'hff : tx_q[i-1];
      for (int k = 7; k >= 0; k--) begin
        if (i > nb && 7 - k >= pb) break;
        serial_clk = 1'b0;
        serial_in = b[k];
        #32 serial_clk = 1'b1;
        r[k] = serial_out;
        #32;
      end
      if (i <= nb) rx_q.push_back(r);
    end
    #40 cs_n = 1'b1;
    serial_in = ~serial_in; // released line must not keep its last level
    #300;
  endtask
endmodule

// file: serial_link_shifter.sv
`timescale 1ns/100ps
// link-side shifter running on the host's serial clock
module serial_link_shifter
  import display_serial_pkg::*;
(
  input  wire logic        serial_clk,
  input  wire logic        cs_n,
  input  wire logic        sys_rst,
  input  wire logic        serial_in,
  input  wire logic        tx_enable,
  input  wire logic [15:0] tx_word,
  output logic [7:0]       rx_byte,
  output logic             rx_toggle,
  output logic             serial_out
);
  logic [2:0]  bit_cnt_r;
  logic [2:0]  byte_cnt_r;
  logic [6:0]  shift_r;
  logic [15:0] tx_sh_r;
  logic        tx_on;

  // direction level from the system side, resynchronised to the link clock
  level_sync u_tx_sync (
    .clk  (serial_clk),
    .arst (cs_n),
    .d    (tx_enable),
    .q    (tx_on)
  );

  // chip select high clears the counters, so a partial byte is dropped
  always_ff @(posedge serial_clk or posedge cs_n) begin
    if (cs_n) begin
      bit_cnt_r  <= 3'h0;
      byte_cnt_r <= 3'h0;
      shift_r    <= 7'h00;
    end else begin
      bit_cnt_r <= bit_cnt_r + 3'h1;
      shift_r   <= {shift_r[5:0], serial_in};
      if (bit_cnt_r == 3'h7) begin
        // after the dummies the count alternates 6,7 for upper/lower byte
        byte_cnt_r <= (byte_cnt_r == LAST_BYTE_COUNT) ? FIRST_DATA_BYTE
                                                      : byte_cnt_r + 3'h1;
      end
    end
  end

  // completed bytes survive chip select rising so the last one still crosses
  always_ff @(posedge serial_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rx_byte   <= BYTE_RESET;
      rx_toggle <= 1'b0;
    end else if (!cs_n && bit_cnt_r == 3'h7) begin
      rx_byte   <= {shift_r, serial_in};
      rx_toggle <= ~rx_toggle;
    end
  end

  // output shifts on the falling edge; the word is taken whole at an upper byte
  always_ff @(negedge serial_clk or posedge cs_n) begin
    if (cs_n) begin
      tx_sh_r    <= WORD_RESET;
      serial_out <= 1'b0;
    end else if (bit_cnt_r == 3'h0 && byte_cnt_r == FIRST_DATA_BYTE && tx_on) begin
      tx_sh_r    <= {tx_word[14:0], 1'b0};
      serial_out <= tx_word[15];
    end else begin
      tx_sh_r    <= {tx_sh_r[14:0], 1'b0};
      serial_out <= tx_sh_r[15];
    end
  end
endmodule

// file: test_display_serial_host_port.sv
`timescale 1ns/100ps
// frames come from the host model; sys-side writes are logged and compared
module test_display_serial_host_port
  import display_serial_pkg::*;
;
  localparam logic [4:0] ID_UP = 5'h0b; // arbitrary identity bits
  logic        sys_clk, rst_n, serial_clk, cs_n, serial_in, serial_out;
  logic        bus_select_pin_3, bus_select_pin_2, bus_select_pin_1, bus_select_low_or_addr_bit;
  logic        index_wr, instr_wr, pixel_wr, rd_req, rd_register_select;
  logic        spi_selected, frame_active, id_mismatch;
  logic [15:0] index_value, instr_word, rd_data, rv0, rv1;
  logic [17:0] pixel_data;
  logic [19:0] ev_q[$], ex_q[$];
  int          fail_count, total_checks, rej, fa_cnt;

  display_serial_host_port #(.ID_UPPER(ID_UP)) i_display_serial_host_port (
    .sys_clk, .rst_n, .serial_clk, .cs_n, .serial_in, .serial_out,
    .bus_select_pin_3, .bus_select_pin_2, .bus_select_pin_1, .bus_select_low_or_addr_bit,
    .index_wr, .index_value, .instr_wr, .instr_word, .pixel_wr, .pixel_data,
    .rd_req, .rd_register_select, .rd_data, .spi_selected, .frame_active, .id_mismatch);
  serial_host_model i_serial_host_model (.serial_clk, .cs_n, .serial_in, .serial_out);

  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  // read word ready one cycle after a request; writes logged by kind
  always @(posedge sys_clk) begin
    rd_data <= rd_register_select ? rv1 : rv0;
    if (index_wr) ev_q.push_back({4'h1, index_value});
    if (instr_wr) ev_q.push_back({4'h2, instr_word});
    if (pixel_wr) ev_q.push_back({2'h3, pixel_data});
    if (id_mismatch) rej++;
    if (frame_active) fa_cnt++;
  end

  function automatic logic [7:0] sb(input logic rs, input logic rw);
    return {ID_UP, bus_select_low_or_addr_bit, rs, rw};
  endfunction

  function automatic logic [17:0] widen(input logic [15:0] w);
    return {w[15:11], w[15], w[10:0], w[4]};
  endfunction

  task automatic chk(input logic [19:0] got, input logic [19:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [15:0] w);
    i_serial_host_model.tx_q.push_back(w[15:8]);
    i_serial_host_model.tx_q.push_back(w[7:0]);
  endtask

  // one frame, then enough sys cycles for the sync chain to deliver
  task automatic run(input logic [7:0] s, input int nb, input int pb, input string nm);
    i_serial_host_model.xfer(s, nb, pb);
    i_serial_host_model.tx_q = {};
    repeat (12) @(posedge sys_clk);
    chk(20'(ev_q.size()), 20'(ex_q.size()));
    foreach (ex_q[i]) begin
      if (i < ev_q.size()) chk(ev_q[i], ex_q[i]);
    end
    // frame seen while chip select was low, and gone once it rose
    chk(20'(fa_cnt > 0), 20'h1);
    chk(frame_active, 1'b0);
    fa_cnt = 0;
    ev_q = {};
    ex_q = {};
    $display("test %s done", nm);
  endtask

  task automatic close_out;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial begin
    #500000;
    fail_count++;
    close_out();
  end

  initial begin
    logic [15:0] v;
    int n;
    void'($urandom(56));
    rst_n = 1'b0;
    fa_cnt = 0;
    rv0 = 16'($urandom);
    rv1 = 16'($urandom);
    // straps and other unused pins stay at fixed levels until the no_mode test drops pin 2
    {bus_select_pin_3, bus_select_pin_2, bus_select_pin_1} = BUS_SEL_SERIAL;
    bus_select_low_or_addr_bit = 1'($urandom);
    repeat (12) @(posedge sys_clk);
    rst_n <= 1'b1;
    n = 0;
    while (spi_selected !== 1'b1 && n < 20) begin
      @(posedge sys_clk);
      n++;
    end
    if (n == 20) chk(1'b0, 1'b1);
    repeat (4) @(posedge sys_clk);
    // index away from pixel memory
    v = 16'($urandom) | 16'h0100;
    wr(v);
    ex_q.push_back({4'h1, v});
    run(sb(1'b0, 1'b0), 2, 0, "index");
    // two instruction words in one frame, odd byte and stray bits dropped
    for (int i = 0; i < 2; i++) begin
      v = 16'($urandom);
      wr(v);
      ex_q.push_back({4'h2, v});
    end
    i_serial_host_model.tx_q.push_back(8'hc3);
    run(sb(1'b1, 1'b0), 5, 3, "instr");
    wr(PIXEL_DATA_REG_INDEX);
    ex_q.push_back({4'h1, PIXEL_DATA_REG_INDEX});
    run(sb(1'b0, 1'b0), 2, 0, "pixel_index");
    for (int i = 0; i < 2; i++) begin
      v = (i == 0) ? 16'h8410 : 16'($urandom);
      wr(v);
      ex_q.push_back({2'h3, widen(v)});
    end
    run(sb(1'b1, 1'b0), 4, 0, "pixel");
    // each identity bit wrong in turn: nothing may land
    for (int k = 2; k < 8; k++) begin
      wr(16'h1234);
      run(sb(1'b0, 1'b0) ^ (8'h01 << k), 2, 0, "bad_id");
    end
    chk(20'(rej), 20'h6);
    // status read then word read, two words each after the dummies
    for (int r = 0; r < 2; r++) begin
      repeat (9) i_serial_host_model.tx_q.push_back(8'h5a);
      run(sb(r[0], 1'b1), 9, 0, "read");
      v = r ? rv1 : rv0;
      chk({4'h0, i_serial_host_model.rx_q[6], i_serial_host_model.rx_q[7]}, v);
      chk({4'h0, i_serial_host_model.rx_q[8], i_serial_host_model.rx_q[9]}, v);
      chk(rd_register_select, r[0]);
    end
    // straps away from serial mode: frame ignored
    bus_select_pin_2 <= 1'b0;
    repeat (6) @(posedge sys_clk);
    chk(spi_selected, 1'b0);
    wr(16'h0001);
    run(sb(1'b0, 1'b0), 2, 0, "no_mode");
    close_out();
  end
endmodule
